// ---- design/rwc_pkg.sv ----
// Shared constants of the reset and watchdog control block: clock rates,
// control and flag bit positions, reset values and window lengths.
// Assumes a single 25 MHz system clock; the watchdog oscillator is an
// enable pulse derived from it.

package rwc_pkg;

  localparam int SYS_CLK_HZ = 25_000_000;   // System clock rate
  localparam int WDT_OSC_HZ = 1_000_000;    // Watchdog oscillator rate
  localparam int WDT_DIV    = SYS_CLK_HZ / WDT_OSC_HZ; // Cycles per tick
  localparam int WDT_DIV_W  = 5;            // Divider counter width
  localparam int WDT_CNT_W  = 22;           // Watchdog counter width
  localparam int WDT_BASE_TICKS = 16384;    // Shortest time-out, 16K
  localparam int DLY_W      = 20;           // Stretch counter width

  // Stretch lengths in oscillator ticks, one per start-up selection
  localparam int TOUT_TICKS_0 = 4;
  localparam int TOUT_TICKS_1 = 4096;
  localparam int TOUT_TICKS_2 = 16384;
  localparam int TOUT_TICKS_3 = 65536;

  localparam logic [2:0] CE_WINDOW_CYC = 3'h4; // Change window, cycles

  // Watchdog control word layout
  localparam int CTRL_W      = 5;
  localparam int CTRL_CE_BIT = 4;
  localparam int CTRL_EN_BIT = 3;
  localparam int PS_W        = 3;
  localparam logic [2:0] PS_RST = 3'h0;

  // Reset flag layout
  localparam int FLAG_W    = 5;
  localparam int FLAG_POR  = 0;
  localparam int FLAG_EXT  = 1;
  localparam int FLAG_BOD  = 2;
  localparam int FLAG_WDT  = 3;
  localparam int FLAG_SCAN = 4;
  localparam logic [4:0] FLAGS_RST = 5'h01;   // Power-on flag only

  localparam logic [2:0] BOD_FUSE_OFF  = 3'h7; // Brown-out disabled code
  localparam logic [3:0] CLOCK_SELECT_FUSE_EXT_CLK = 4'h0; // External clock code

endpackage

// ---- design/rwc_sync3.sv ----
// Three-stage input synchroniser for levels from outside the clock.
// Assumes inputs hold each level for at least three clock cycles.
`timescale 1ns/10ps
`default_nettype none

module rwc_sync3 #(
  parameter int W = 4
) (
  input  wire  logic         clk_in,
  input  wire  logic         rst_in,
  input  wire  logic [W-1:0] d_in,
  output var   logic [W-1:0] q_out
);

  typedef struct packed {
    logic [W-1:0] s1;   // Metastable catch, read by s2 only
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;    // Agreed value
  } rwc_sync_t;

  rwc_sync_t st_ff;
  rwc_sync_t nxt_st;

  if (W < 1) begin : g_bad_w
    $error("synchroniser width must be at least one");
  end

  // Shift, and accept a change once the last two stages agree
  always_comb begin
    nxt_st    = st_ff;
    nxt_st.s1 = d_in;
    nxt_st.s2 = st_ff.s1;
    nxt_st.s3 = st_ff.s2;
    for (int i = 0; i < W; i++) begin
      if (st_ff.s2[i] == st_ff.s3[i]) begin
        nxt_st.q[i] = st_ff.s3[i];
      end
    end
  end

  // State register
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign q_out = st_ff.q;

endmodule

`default_nettype wire

// ---- design/rwc_stretch.sv ----
// Reset stretcher: asserts at once on any active source, releases a
// chosen number of oscillator ticks after the last source goes away.
// Assumes src_in is the already combined, active-high source level.
`timescale 1ns/10ps
`default_nettype none

module rwc_stretch #(
  parameter int CNT_W = 20
) (
  input  wire  logic             clk_in,
  input  wire  logic             src_in,
  input  wire  logic             tick_in,
  input  wire  logic [CNT_W-1:0] delay_in,
  output var   logic             reset_out
);

  typedef struct packed {
    logic             rel1;  // Release catch, read by rel2 only
    logic             rel2;  // Released source, synchronous
    logic [CNT_W-1:0] cnt;   // Ticks since release
    logic             hold;  // Internal reset
  } rwc_str_t;

  localparam rwc_str_t STR_RST = '{1'b1, 1'b1, '0, 1'b1};

  rwc_str_t st_ff;
  rwc_str_t nxt_st;

  if (CNT_W < 2) begin : g_bad_w
    $error("stretch counter too narrow");
  end

  // Count ticks once the release has passed two flops
  always_comb begin
    nxt_st      = st_ff;
    nxt_st.rel1 = 1'b0;
    nxt_st.rel2 = st_ff.rel1;
    if (st_ff.rel2) begin
      nxt_st.cnt  = '0;
      nxt_st.hold = 1'b1;
    end else if (st_ff.hold && tick_in) begin
      if (st_ff.cnt >= delay_in) begin
        nxt_st.hold = 1'b0;
      end else begin
        nxt_st.cnt = st_ff.cnt + CNT_W'(1);
      end
    end
  end

  // Source sets everything at once, no clock needed
  always_ff @(posedge clk_in or posedge src_in) begin
    if (src_in) begin
      st_ff <= STR_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign reset_out = st_ff.hold;

endmodule

`default_nettype wire

// ---- design/rwc_reset_ctrl.sv ----
// Reset and watchdog control: merges the reset sources, stretches the
// internal reset, runs the watchdog and keeps the reset flags.
// Assumes fuse inputs are static after power-up and the CPU decodes
// the control and flag writes into the strobes below.
`timescale 1ns/10ps
`default_nettype none

module rwc_reset_ctrl #(
  parameter int WDT_BASE_TICKS = rwc_pkg::WDT_BASE_TICKS,
  parameter int TOUT_TICKS_0   = rwc_pkg::TOUT_TICKS_0,
  parameter int TOUT_TICKS_1   = rwc_pkg::TOUT_TICKS_1,
  parameter int TOUT_TICKS_2   = rwc_pkg::TOUT_TICKS_2,
  parameter int TOUT_TICKS_3   = rwc_pkg::TOUT_TICKS_3
) (
  input  wire  logic       clk_in,
  input  wire  logic       rst_in,
  input  wire  logic       por_detect_in,
  input  wire  logic       ext_reset_n_in,
  input  wire  logic       brownout_low_in,
  input  wire  logic       scan_reset_in,
  input  wire  logic [2:0] brownout_level_fuse_in,
  input  wire  logic       watchdog_always_on_fuse_in,
  input  wire  logic [1:0] startup_time_fuse_in,
  input  wire  logic [3:0] clock_select_fuse_in,
  input  wire  logic       comparator_bandgap_select_in,
  input  wire  logic       adc_enable_in,
  input  wire  logic       wdt_restart_in,
  input  wire  logic       wdt_ctrl_wr_in,
  input  wire  logic [4:0] wdt_ctrl_data_in,
  input  wire  logic       flags_wr_in,
  input  wire  logic [4:0] flags_data_in,
  output var   logic       chip_reset_out,
  output var   logic [4:0] wdt_ctrl_out,
  output var   logic [4:0] reset_flags_out,
  output var   logic       bandgap_enable_out,
  output var   logic       wdt_expired_out
);

  localparam int CW = rwc_pkg::WDT_CNT_W;
  localparam int DW = rwc_pkg::DLY_W;
  localparam int VW = rwc_pkg::WDT_DIV_W;
  localparam int EN = rwc_pkg::CTRL_EN_BIT;
  localparam int CE = rwc_pkg::CTRL_CE_BIT;

  typedef struct packed {
    logic [VW-1:0] div;     // Oscillator divider
    logic          tick;    // One pulse per oscillator period
    logic [CW-1:0] wcnt;    // Watchdog tick counter
    logic          wpulse;  // Expiry pulse, one cycle
    logic          en;      // Watchdog enable as read back
    logic          ce;      // Change enable
    logic [2:0]    cecnt;   // Cycles left in change window
    logic [2:0]    ps;      // Prescale select
    logic [4:0]    flags;   // Reset cause flags
    logic          bg;      // Bandgap enable
  } rwc_state_t;

  localparam rwc_state_t ST_RST = '{
    div: '0, tick: 1'b0, wcnt: '0, wpulse: 1'b0, en: 1'b0,
    ce: 1'b0, cecnt: 3'h0, ps: rwc_pkg::PS_RST,
    flags: rwc_pkg::FLAGS_RST, bg: 1'b0};

  rwc_state_t    st_ff;       // All state of this module
  rwc_state_t    nxt_st;      // Its next value
  logic [3:0]    src_raw;     // Pin-side sources, active high
  logic [3:0]    src_s;       // Same, synchronised
  logic          bod_on;      // Brown-out detector enabled by fuse
  logic          src_async;   // Combined sources, unclocked
  logic [DW-1:0] dly_ticks;   // Selected stretch length
  logic [CW-1:0] wdt_lim;     // Last tick count before expiry
  logic          lvl2;        // Safety level two
  logic          d_ce;        // Written change enable
  logic          d_en;        // Written enable
  logic [2:0]    d_ps;        // Written prescale

  // Refuse counts the counters cannot hold
  if (WDT_BASE_TICKS < 1 || WDT_BASE_TICKS * 128 >= 2 ** CW)
  begin : g_bad_base
    $error("watchdog base count does not fit the counter");
  end
  if (TOUT_TICKS_0 < 0 || TOUT_TICKS_3 >= 2 ** DW ||
      TOUT_TICKS_1 >= 2 ** DW || TOUT_TICKS_2 >= 2 ** DW)
  begin : g_bad_tout
    $error("stretch count does not fit the counter");
  end

  // Last tick before expiry, base count doubled per prescale step
  function automatic logic [CW-1:0] wdt_limit(input logic [2:0] ps);
    logic [CW-1:0] base;
    base      = CW'(WDT_BASE_TICKS);
    wdt_limit = (base << ps) - CW'(1);
  endfunction

  // Stretch length picked by fuses; external clock takes the shortest
  function automatic logic [DW-1:0] dly_sel(input logic [3:0] cks,
                                            input logic [1:0] startup_time_fuse);
    if (cks == rwc_pkg::CLOCK_SELECT_FUSE_EXT_CLK) begin
      dly_sel = DW'(TOUT_TICKS_0);
    end else if (startup_time_fuse == 2'h0) begin
      dly_sel = DW'(TOUT_TICKS_0);
    end else if (startup_time_fuse == 2'h1) begin
      dly_sel = DW'(TOUT_TICKS_1);
    end else if (startup_time_fuse == 2'h2) begin
      dly_sel = DW'(TOUT_TICKS_2);
    end else begin
      dly_sel = DW'(TOUT_TICKS_3);
    end
  endfunction

  assign bod_on  = brownout_level_fuse_in != rwc_pkg::BOD_FUSE_OFF;
  assign lvl2    = watchdog_always_on_fuse_in;
  assign d_ce    = wdt_ctrl_data_in[CE];
  assign d_en    = wdt_ctrl_data_in[EN];
  assign d_ps    = wdt_ctrl_data_in[2:0];
  assign wdt_lim = wdt_limit(st_ff.ps);
  assign dly_ticks = dly_sel(clock_select_fuse_in, startup_time_fuse_in);
  assign src_raw = {scan_reset_in, brownout_low_in,
                    ~ext_reset_n_in, por_detect_in};

  // Unclocked merge: pins must reset the chip with no clock running.
  // Glitches here only lengthen reset, which is the safe direction.
  assign src_async = rst_in | por_detect_in
                   | ~ext_reset_n_in
                   | (brownout_low_in & bod_on)
                   | scan_reset_in
                   | st_ff.wpulse;

  // Pin levels for the flags pass four flops
  rwc_sync3 #(
    .W (4)
  ) u_sync (
    .clk_in (clk_in),
    .rst_in (rst_in),
    .d_in   (src_raw),
    .q_out  (src_s)
  );

  // Stretcher drives the internal reset straight from its flop
  rwc_stretch #(
    .CNT_W (DW)
  ) u_stretch (
    .clk_in    (clk_in),
    .src_in    (src_async),
    .tick_in   (st_ff.tick),
    .delay_in  (dly_ticks),
    .reset_out (chip_reset_out)
  );

  // Next state: divider, control word, watchdog, flags, bandgap
  always_comb begin
    nxt_st = st_ff;

    // Oscillator period as an enable pulse
    if (st_ff.div == VW'(rwc_pkg::WDT_DIV - 1)) begin
      nxt_st.div  = '0;
      nxt_st.tick = 1'b1;
    end else begin
      nxt_st.div  = st_ff.div + VW'(1);
      nxt_st.tick = 1'b0;
    end

    // Change window runs down and closes on its own
    if (st_ff.cecnt != 3'h0) begin
      nxt_st.cecnt = st_ff.cecnt - 3'h1;
      if (st_ff.cecnt == 3'h1) begin
        nxt_st.ce = 1'b0;
      end
    end

    // Control writes
    if (wdt_ctrl_wr_in) begin
      if (d_ce && d_en) begin
        // First step opens the window; prescale stays put
        nxt_st.ce    = 1'b1;
        nxt_st.cecnt = rwc_pkg::CE_WINDOW_CYC;
        nxt_st.en    = 1'b1;
      end else if (st_ff.ce && !d_ce) begin
        // Second step inside the window takes enable and prescale
        nxt_st.en    = d_en;
        nxt_st.ps    = d_ps;
        nxt_st.ce    = 1'b0;
        nxt_st.cecnt = 3'h0;
      end else if (d_en) begin
        // Enabling needs no sequence; clearing here is ignored
        nxt_st.en = 1'b1;
      end
    end

    // Level two: enable is pinned, so the second step's enable bit is moot
    if (lvl2) begin
      nxt_st.en = 1'b1;
    end

    // Chip reset returns the control word to its initial value, except enable, which takes the level-two fuse
    if (chip_reset_out) begin
      nxt_st.en    = lvl2;
      nxt_st.ce    = 1'b0;
      nxt_st.cecnt = 3'h0;
      nxt_st.ps    = rwc_pkg::PS_RST;
    end

    // Watchdog counter and its expiry pulse
    nxt_st.wpulse = 1'b0;
    if (chip_reset_out || wdt_restart_in || !st_ff.en) begin
      nxt_st.wcnt = '0;
    end else if (st_ff.tick) begin
      if (st_ff.wcnt >= wdt_lim) begin
        nxt_st.wcnt   = '0;
        nxt_st.wpulse = 1'b1;
      end else begin
        nxt_st.wcnt = st_ff.wcnt + CW'(1);
      end
    end

    // Flags: zero write clears, a set in the same cycle wins
    if (flags_wr_in) begin
      nxt_st.flags = st_ff.flags & flags_data_in;
    end
    if (src_s[0]) begin
      nxt_st.flags = rwc_pkg::FLAGS_RST;
    end else begin
      nxt_st.flags[rwc_pkg::FLAG_EXT]  = nxt_st.flags[rwc_pkg::FLAG_EXT]
                                         | src_s[1];
      nxt_st.flags[rwc_pkg::FLAG_BOD]  = nxt_st.flags[rwc_pkg::FLAG_BOD]
                                         | (src_s[2] & bod_on);
      nxt_st.flags[rwc_pkg::FLAG_WDT]  = nxt_st.flags[rwc_pkg::FLAG_WDT]
                                         | st_ff.wpulse;
      nxt_st.flags[rwc_pkg::FLAG_SCAN] = nxt_st.flags[rwc_pkg::FLAG_SCAN]
                                         | src_s[3];
    end

    // Reference is needed by any of its three users
    nxt_st.bg = bod_on | comparator_bandgap_select_in
              | adc_enable_in;
  end

  // State register; flags survive chip reset, only rst_in clears all
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      st_ff <= ST_RST;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign wdt_ctrl_out       = {st_ff.ce, st_ff.en, st_ff.ps};
  assign reset_flags_out    = st_ff.flags;
  assign bandgap_enable_out = st_ff.bg;
  assign wdt_expired_out    = st_ff.wpulse;

  // Expiry pulse lasts exactly one cycle
  property p_pulse_one;
    @(posedge clk_in) disable iff (rst_in)
      st_ff.wpulse |=> !st_ff.wpulse;
  endproperty
  a_pulse_one: assert property (p_pulse_one)
    else $error("watchdog pulse longer than one cycle");

  // Expiry pulse puts the chip into a stretched reset
  property p_pulse_reset;
    @(posedge clk_in) disable iff (rst_in)
      st_ff.wpulse |=> chip_reset_out [*2];
  endproperty
  a_pulse_reset: assert property (p_pulse_reset)
    else $error("watchdog expiry did not hold reset");

  // Scan reset keeps the chip in reset
  property p_scan_hold;
    @(posedge clk_in) disable iff (rst_in)
      src_s[3] |-> chip_reset_out;
  endproperty
  a_scan_hold: assert property (p_scan_hold)
    else $error("scan reset not holding chip reset");

  // Change enable lives four cycles when no write or reset cuts it short
  property p_ce_life;
    @(posedge clk_in) disable iff (rst_in)
      $rose(st_ff.ce) && !chip_reset_out && !wdt_ctrl_wr_in
        ##1 (!wdt_ctrl_wr_in && !chip_reset_out) [*3]
        |-> st_ff.ce ##1 !st_ff.ce;
  endproperty
  a_ce_life: assert property (p_ce_life)
    else $error("change enable window has wrong length");

  // Bandgap follows its three users one cycle later
  property p_bandgap;
    @(posedge clk_in) disable iff (rst_in)
      (bod_on || comparator_bandgap_select_in || adc_enable_in)
        |=> st_ff.bg;
  endproperty
  a_bandgap: assert property (p_bandgap)
    else $error("bandgap off while a user needs it");

  // Restart clears the counter
  property p_restart;
    @(posedge clk_in) disable iff (rst_in)
      wdt_restart_in |=> st_ff.wcnt == '0;
  endproperty
  a_restart: assert property (p_restart)
    else $error("watchdog restart did not clear the counter");

  logic [VW-1:0] tick_gap_ff;   // Cycles since last tick, checker only

  // Checker count; all ones at reset so the first tick lines up too
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      tick_gap_ff <= '1;
    end else if (st_ff.tick) begin
      tick_gap_ff <= '0;
    end else begin
      tick_gap_ff <= tick_gap_ff + VW'(1);
    end
  end

  // Oscillator tick period is exactly the divide ratio
  property p_tick;
    @(posedge clk_in) disable iff (rst_in)
      st_ff.tick == (tick_gap_ff == VW'(rwc_pkg::WDT_DIV - 1));
  endproperty
  a_tick: assert property (p_tick)
    else $error("watchdog oscillator period wrong");

  // Level two always reads enabled
  property p_lvl2;
    @(posedge clk_in) disable iff (rst_in)
      lvl2 |=> wdt_ctrl_out[EN];
  endproperty
  a_lvl2: assert property (p_lvl2)
    else $error("level two watchdog reads disabled");

  // Level one single write enables
  property p_lvl1_en;
    @(posedge clk_in) disable iff (rst_in)
      wdt_ctrl_wr_in && d_en && !chip_reset_out |=> st_ff.en;
  endproperty
  a_lvl1_en: assert property (p_lvl1_en)
    else $error("enable write did not enable watchdog");

  // Clearing enable outside the window is ignored
  property p_no_disable;
    @(posedge clk_in) disable iff (rst_in)
      st_ff.en && !st_ff.ce && wdt_ctrl_wr_in && !d_ce
        && !chip_reset_out |=> st_ff.en;
  endproperty
  a_no_disable: assert property (p_no_disable)
    else $error("watchdog disabled without timed sequence");

  // Period elapsed without restart gives the expiry pulse
  property p_timeout;
    @(posedge clk_in) disable iff (rst_in)
      st_ff.tick && st_ff.en && !chip_reset_out && !wdt_restart_in
        && st_ff.wcnt == wdt_lim |=> st_ff.wpulse;
  endproperty
  a_timeout: assert property (p_timeout)
    else $error("watchdog did not expire at its limit");

  // Power-on leaves only its own flag
  property p_por_flag;
    @(posedge clk_in) disable iff (rst_in)
      src_s[0] |=> st_ff.flags == rwc_pkg::FLAGS_RST;
  endproperty
  a_por_flag: assert property (p_por_flag)
    else $error("power-on did not reset the flags");

endmodule

`default_nettype wire

// ---- tb/rwc_reset_ctrl_tb.sv ----
// Bench for the reset and watchdog control block: drives reset sources,
// fuses and control writes, and checks every output it can predict.
// Assumes the shortened watchdog and stretch counts set below.
`timescale 1ns/10ps
`default_nettype none

module rwc_reset_ctrl_tb;
  logic       clk_in = 1'b0;   // System clock
  logic       rst_in = 1'b1;   // Async reset
  logic       por    = 1'b0;   // Power-on detect
  logic       ext_n  = 1'b1;   // External pin, low resets
  logic       brownout_detector    = 1'b0;   // Supply low
  logic       scan   = 1'b0;   // Scan reset bit
  logic [2:0] bfuse  = 3'h7;   // Brown-out fuse, off at first
  logic       lvl2   = 1'b0;   // Always-on fuse
  logic       comparator_bandgap_select   = 1'b0;   // Comparator bandgap select
  logic       adc    = 1'b0;   // Converter enable
  logic       rstrt  = 1'b0;   // Watchdog restart
  logic       cwr    = 1'b0;   // Control write strobe
  logic       fwr    = 1'b0;   // Flag write strobe
  logic [4:0] cdat   = 5'h00;  // Control write data
  logic [1:0] startup_time_fuse    = 2'h0;   // Start-up time fuse
  logic [3:0] cks    = 4'h1;   // Clock select fuse
  logic [4:0] fdat   = 5'h00;  // Flag write data
  logic [4:0] ctrl;            // Control readback
  logic [4:0] flags;           // Reset flags
  logic       chip, bg, expd;  // Reset, bandgap, expiry pulse
  int         num_errors = 0;
  int         total_checks = 0;
  int         cycles = 0;
  int         n, p, e, w, d;

  // Short counts keep the run small; expectations derive from these
  rwc_reset_ctrl #(.WDT_BASE_TICKS(4), .TOUT_TICKS_0(1), .TOUT_TICKS_1(2),
    .TOUT_TICKS_2(3), .TOUT_TICKS_3(4)) rwc_reset_ctrl_inst (
    .clk_in(clk_in), .rst_in(rst_in), .por_detect_in(por),
    .ext_reset_n_in(ext_n), .brownout_low_in(brownout_detector), .scan_reset_in(scan),
    .brownout_level_fuse_in(bfuse), .watchdog_always_on_fuse_in(lvl2),
    .startup_time_fuse_in(startup_time_fuse), .clock_select_fuse_in(cks),
    .comparator_bandgap_select_in(comparator_bandgap_select), .adc_enable_in(adc),
    .wdt_restart_in(rstrt), .wdt_ctrl_wr_in(cwr), .wdt_ctrl_data_in(cdat),
    .flags_wr_in(fwr), .flags_data_in(fdat), .chip_reset_out(chip),
    .wdt_ctrl_out(ctrl), .reset_flags_out(flags),
    .bandgap_enable_out(bg), .wdt_expired_out(expd));

  // Free-running clock
  always #20 clk_in = ~clk_in;

  // Hang guard: the whole sequence needs about 30000 cycles
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      complete_run();
    end
  end

  // Verdict and end of run
  task automatic complete_run;
    if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  // Compare a value of up to five bits
  task automatic chk(input string nm, input logic [4:0] ex,
                     input logic [4:0] got);
    total_checks++;
    if (got !== ex) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, ex, got);
    end
  endtask

  // Stretch ticks the fuses select, from the short counts set above
  function automatic int tout(input logic [1:0] s, input logic [3:0] c);
    if (c == 4'h0) return 1;
    return int'(s) + 1;
  endfunction

  // Drop strobes, then let k edges pass; inputs move 2 ns after edges
  task automatic cyc(input int k);
    cwr = 1'b0;
    rstrt = 1'b0;
    fwr = 1'b0;
    repeat (k) @(posedge clk_in);
    #2;
  endtask

  // Control write; strobe stays up so writes may run back to back
  task automatic wr(input logic [4:0] d);
    cdat = d;
    cwr = 1'b1;
    @(posedge clk_in);
    #2;
  endtask

  // Clear all flags by a zero write
  task automatic clrf;
    fdat = 5'h00;
    fwr = 1'b1;
    @(posedge clk_in);
    #2;
    chk("flags_clear", 5'h00, flags);
    cyc(1);
  endtask

  // Reset must outlast its source, then release within a bound
  task automatic rel;
    cyc(1);
    chk("stretch", 5'h01, {4'h0, chip});
    n = 0;
    while (chip === 1'b1 && n < 400) begin
      cyc(1);
      n++;
    end
    chk("release", 5'h00, {4'h0, chip});
    d = 25 * tout(startup_time_fuse, cks);
    chk("stretch_len", 5'h01, {4'h0, n > d && n < d + 28});
  endtask

  initial begin
    void'($urandom(97157));
    startup_time_fuse = 2'($urandom);
    repeat (8) @(posedge clk_in);
    #2;
    chk("flags_rst", 5'h01, flags);
    chk("ctrl_rst", 5'h00, ctrl);
    chk("chip_rst", 5'h01, {4'h0, chip});
    rst_in = 1'b0;
    rel();
    clrf();
    // Bandgap users with the brown-out fuse off
    repeat (8) begin
      comparator_bandgap_select = 1'($urandom);
      adc = 1'($urandom);
      cyc(2);
      chk("bandgap", {4'h0, comparator_bandgap_select | adc}, {4'h0, bg});
    end
    comparator_bandgap_select = 1'b0;
    adc = 1'b0;
    // Level one: plain enable, refused plain disable
    wr(5'h08);
    chk("enable", 5'h08, ctrl);
    wr(5'h00);
    chk("no_disable", 5'h08, ctrl);
    // Step two on the last edge of the window
    wr(5'h18);
    cyc(3);
    chk("ce_held", 5'h18, ctrl);
    wr(5'h05);
    chk("late_ok", 5'h05, ctrl);
    // Window closed: step two one edge too late is ignored
    wr(5'h18);
    cyc(4);
    chk("ce_clear", 5'h0D, ctrl);
    wr(5'h02);
    chk("refused", 5'h0D, ctrl);
    // Random step two after a random gap inside the window
    repeat (6) begin
      w = $urandom % 4;
      e = $urandom % 16;
      wr(5'h18);
      if (w > 0) cyc(w);
      wr(5'(e));
      chk("step_two", 5'(e), ctrl);
    end
    wr(5'h18);
    wr(5'h00);
    // Every prescale code: expiry time, pulse and flag
    for (p = 0; p < 8; p++) begin
      wr(5'h18);
      wr(5'(p));
      wr(5'(p) | 5'h08);
      chk("armed", 5'(p) | 5'h08, ctrl);
      e = (4 << p) * 25;
      n = 0;
      while (expd !== 1'b1 && n < 14000) begin
        cyc(1);
        n++;
      end
      chk("period", 5'h01, {4'h0, n >= e - 27 && n <= e + 30});
      cyc(1);
      chk("pulse_end", 5'h00, {4'h0, expd});
      chk("wdt_reset", 5'h01, {4'h0, chip});
      chk("wdt_flag", 5'h08, flags);
      rel();
      chk("ctrl_clr", 5'h00, ctrl);
      fdat = 5'($urandom);
      fwr = 1'b1;
      @(posedge clk_in);
      #2;
      chk("flags_keep", 5'h08 & fdat, flags);
      clrf();
    end
    // Restarts inside the shortest period keep the watchdog quiet
    wr(5'h08);
    repeat (10) begin
      cyc(30 + $urandom % 30);
      rstrt = 1'b1;
      @(posedge clk_in);
      #2;
    end
    chk("kept_alive", 5'h00, {flags[3], 3'h0, chip});
    wr(5'h18);
    wr(5'h00);
    // External pin resets without a clock edge
    ext_n = 1'b0;
    #1 chk("ext_now", 5'h01, {4'h0, chip});
    cyc(5);
    ext_n = 1'b1;
    rel();
    chk("ext_flag", 5'h02, flags);
    clrf();
    // Scan bit holds reset as long as it stays one
    scan = 1'b1;
    cyc(200);
    chk("scan_hold", 5'h01, {4'h0, chip});
    scan = 1'b0;
    rel();
    chk("scan_flag", 5'h10, flags);
    clrf();
    // Supply low is ignored while the detector is fused off
    brownout_detector = 1'b1;
    cyc(5);
    brownout_detector = 1'b0;
    cyc(5);
    chk("bod_off", 5'h00, {flags[2], 3'h0, chip});
    // Power-on detect
    por = 1'b1;
    #1 chk("por_now", 5'h01, {4'h0, chip});
    cyc(5);
    por = 1'b0;
    rel();
    chk("por_flag", 5'h01, flags);
    clrf();
    // Level two with brown-out fused on; fuses change only in reset
    rst_in = 1'b1;
    lvl2 = 1'b1;
    bfuse = 3'h4;
    cks = 4'h0;
    startup_time_fuse = 2'($urandom);
    cyc(3);
    rst_in = 1'b0;
    rel();
    chk("lvl2_on", 5'h08, ctrl);
    chk("bg_bod", 5'h01, {4'h0, bg});
    clrf();
    wr(5'h00);
    chk("lvl2_keep", 5'h08, ctrl);
    wr(5'h18);
    wr(5'h05);
    chk("lvl2_ps", 5'h0D, ctrl);
    // Enabled brown-out resets at once
    brownout_detector = 1'b1;
    #1 chk("bod_now", 5'h01, {4'h0, chip});
    cyc(5);
    brownout_detector = 1'b0;
    rel();
    chk("bod_flag", 5'h04, flags);
    complete_run();
  end
endmodule

`default_nettype wire
